// [rtl/pls_pkg.sv]
package pls_pkg;

   // Timing figures and derived cycle counts at the 100 MHz system clock.
   localparam int unsigned CLK_HZ             = 100_000_000;
   localparam int unsigned FILT_TIME_US       = 50;
   localparam int unsigned FILT_CYCLES        = FILT_TIME_US * (CLK_HZ / 1_000_000);
   localparam int unsigned BO_FILT_TIME_US    = 20;
   localparam int unsigned BO_FILT_CYCLES     = BO_FILT_TIME_US * (CLK_HZ / 1_000_000);
   localparam int unsigned START_DELAY_MS     = 100;
   localparam int unsigned START_DELAY_CYCLES = START_DELAY_MS * (CLK_HZ / 1_000);
   localparam int unsigned FAST_REACT_NS      = 120;
   localparam int unsigned FAST_REACT_CYCLES  = FAST_REACT_NS / (1_000_000_000 / CLK_HZ);

   // Width of the counter that times the start delay and the sync clamp.
   localparam int unsigned TMR_W = 24;

   // Start-up and run phases of the sequencer.
   typedef enum logic [2:0]
   {
      PLS_OFF,
      PLS_DELAY,
      PLS_PREHEAT,
      PLS_SOFTSTART,
      PLS_RUN
   } pls_phase_t;

endpackage

// [rtl/pls_sync.sv]
module pls_sync
   import pls_pkg::*;
(
   // Clock and reset.
   input  wire logic clk_sys,
   input  wire logic arst_n,
   // Asynchronous level in, synchronised level out.
   input  wire logic din,
   output logic      dout
);

   logic meta_q;
   logic sync_q;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end
      else
      begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;

endmodule

// [rtl/pls_filter.sv]
module pls_filter
   import pls_pkg::*;
#(
   parameter int unsigned COUNT = FILT_CYCLES
)
(
   // Clock and reset.
   input  wire logic clk_sys,
   input  wire logic arst_n,
   // Synchronised raw level, enable and filtered result.
   input  wire logic din,
   input  wire logic enable,
   output logic      dout
);

   localparam int unsigned CW = $clog2(COUNT + 1);
   localparam logic [CW-1:0] TERM = CW'(COUNT - 1);

   logic [CW-1:0] cnt_q;
   logic          out_q;

   // Counter restarts whenever the input drops; reports only at terminal count.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_q <= '0;
         out_q <= 1'b0;
      end
      else if (!din || !enable)
      begin
         cnt_q <= '0;
         out_q <= 1'b0;
      end
      else if (cnt_q == TERM)
      begin
         out_q <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   assign dout = out_q;

endmodule

// [rtl/pls_sequencer.sv]
module pls_sequencer
   import pls_pkg::*;
#(
   parameter int unsigned START_DELAY = START_DELAY_CYCLES,
   parameter int unsigned FILT        = FILT_CYCLES,
   parameter int unsigned BO_FILT     = BO_FILT_CYCLES
)
(
   // Clock and supply-level reset.
   input  wire logic            clk_sys,
   input  wire logic            arst_n,
   // Comparator pins from the analog front end.
   input  wire logic            supply_ok_in,
   input  wire logic            brownout_detect_input,
   input  wire logic            overtemp_trip_in,
   input  wire logic            latching_shutdown_input,
   input  wire logic            fast_shutdown_input,
   input  wire logic            preheat_timer,
   input  wire logic            softstart_done_in,
   input  wire logic            boot_uvlo_in,
   // Gate commands from the oscillator and the sync clamp setting.
   input  wire logic            osc_low_in,
   input  wire logic            osc_high_in,
   input  wire logic [TMR_W-1:0] sync_clamp_cycles,
   // Gate and sync outputs.
   output logic                 low_gate_out,
   output logic                 high_gate_out,
   output logic                 low_sync_out,
   output logic                 high_sync_out,
   // Status.
   output logic                 overtemp_latched,
   output logic                 shutdown_latched,
   output logic                 running,
   output logic                 preheat_active,
   output logic                 softstart_active
);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers and filters.

   logic sup_s;
   logic bo_s;
   logic ot_s;
   logic sd_s;
   logic fs_s;
   logic ph_s;
   logic ss_s;
   logic uv_s;
   logic ol_s;
   logic oh_s;

   pls_sync u_sync_sup (.clk_sys(clk_sys), .arst_n(arst_n), .din(supply_ok_in), .dout(sup_s));
   pls_sync u_sync_bo (.clk_sys(clk_sys), .arst_n(arst_n), .din(brownout_detect_input),
                       .dout(bo_s));
   pls_sync u_sync_ot (.clk_sys(clk_sys), .arst_n(arst_n), .din(overtemp_trip_in), .dout(ot_s));
   pls_sync u_sync_sd (.clk_sys(clk_sys), .arst_n(arst_n), .din(latching_shutdown_input),
                       .dout(sd_s));
   pls_sync u_sync_fs (.clk_sys(clk_sys), .arst_n(arst_n), .din(fast_shutdown_input),
                       .dout(fs_s));
   pls_sync u_sync_ph (.clk_sys(clk_sys), .arst_n(arst_n), .din(preheat_timer), .dout(ph_s));
   pls_sync u_sync_ss (.clk_sys(clk_sys), .arst_n(arst_n), .din(softstart_done_in),
                       .dout(ss_s));
   pls_sync u_sync_uv (.clk_sys(clk_sys), .arst_n(arst_n), .din(boot_uvlo_in), .dout(uv_s));
   pls_sync u_sync_ol (.clk_sys(clk_sys), .arst_n(arst_n), .din(osc_low_in), .dout(ol_s));
   pls_sync u_sync_oh (.clk_sys(clk_sys), .arst_n(arst_n), .din(osc_high_in), .dout(oh_s));

   pls_phase_t phase_q;
   logic       bo_low_f;
   logic       ot_f;
   logic       sd_f;
   logic       ot_en;
   logic       sd_en;

   // Over-temperature only counts once the start-up sequence is over.
   assign ot_en = (phase_q == PLS_RUN);
   // Latching shutdown only counts once preheat has finished.
   assign sd_en = (phase_q == PLS_SOFTSTART) || (phase_q == PLS_RUN);

   pls_filter #(.COUNT(BO_FILT)) u_filt_bo
   (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .din     (!bo_s),
      .enable  (1'b1),
      .dout    (bo_low_f)
   );

   pls_filter #(.COUNT(FILT)) u_filt_ot
   (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .din     (ot_s),
      .enable  (ot_en),
      .dout    (ot_f)
   );

   pls_filter #(.COUNT(FILT)) u_filt_sd
   (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .din     (sd_s),
      .enable  (sd_en),
      .dout    (sd_f)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Fault latches.

   logic ot_lat_q;
   logic sd_lat_q;
   logic clear_ev;

   // Both latches clear on supply loss or a brown-out re-trigger, the shutdown latch only while its input is low.
   assign clear_ev = !sup_s || bo_low_f;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         ot_lat_q <= 1'b0;
      else if (ot_f)
         ot_lat_q <= 1'b1;
      else if (clear_ev)
         ot_lat_q <= 1'b0;
   end

   // The comparator's own hysteresis sets the release point; a latched trip
   // cannot restart until the input is below it and a clear event has come.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         sd_lat_q <= 1'b0;
      else if (sd_f)
         sd_lat_q <= 1'b1;
      else if (clear_ev && !sd_s)
         sd_lat_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Start-up sequencer.

   logic             halt;
   logic [TMR_W-1:0] dly_q;

   localparam logic [TMR_W-1:0] DLY_TERM = TMR_W'(START_DELAY - 1);

   // Any halt drops the phase to off, so every restart re-runs the full sequence.
   assign halt = !sup_s || bo_low_f || fs_s || ot_lat_q || sd_lat_q;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         phase_q <= PLS_OFF;
      else if (halt)
         phase_q <= PLS_OFF;
      else
      begin
         case (phase_q)
            PLS_OFF:
               phase_q <= PLS_DELAY;
            PLS_DELAY:
               if (dly_q == DLY_TERM)
                  phase_q <= PLS_PREHEAT;
            PLS_PREHEAT:
               if (ph_s)
                  phase_q <= PLS_SOFTSTART;
            PLS_SOFTSTART:
               if (ss_s)
                  phase_q <= PLS_RUN;
            PLS_RUN:
               phase_q <= PLS_RUN;
            default:
               phase_q <= PLS_OFF;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         dly_q <= '0;
      else if (phase_q != PLS_DELAY || halt)
         dly_q <= '0;
      else if (dly_q != DLY_TERM)
         dly_q <= dly_q + TMR_W'(1);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gate ordering and output gating.

   logic drive_ok;
   logic low_first_q;
   logic ol_q;
   logic oh_q;
   logic gl_q;
   logic gh_q;

   assign drive_ok = (phase_q == PLS_PREHEAT) || (phase_q == PLS_SOFTSTART) ||
                     (phase_q == PLS_RUN);

   // Set on every restart; cleared once the low side has pulsed.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         low_first_q <= 1'b1;
      else if (!drive_ok)
         low_first_q <= 1'b1;
      else if (gl_q)
         low_first_q <= 1'b0;
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         gl_q <= 1'b0;
         gh_q <= 1'b0;
      end
      else
      begin
         gl_q <= drive_ok && ol_s;
         gh_q <= drive_ok && oh_s && !low_first_q && !uv_s;
      end
   end

   logic kill;

   // Fast shutdown and both latches blank the outputs straight away, so the
   // outputs never wait for the phase to fall back to off.
   assign kill          = fs_s || ot_lat_q || sd_lat_q;
   assign low_gate_out  = gl_q && !kill;
   assign high_gate_out = gh_q && !kill;

   ////////////////////////////////////////////////////////////////////////////
   // Sync output on-time clamp.

   logic [TMR_W-1:0] sl_cnt_q;
   logic [TMR_W-1:0] sh_cnt_q;
   logic             sl_q;
   logic             sh_q;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ol_q     <= 1'b0;
         oh_q     <= 1'b0;
         sl_cnt_q <= '0;
         sh_cnt_q <= '0;
      end
      else
      begin
         ol_q     <= gl_q;
         oh_q     <= gh_q;
         sl_cnt_q <= (gl_q && !ol_q) ? TMR_W'(1) : (gl_q ? sl_cnt_q + TMR_W'(1) : '0);
         sh_cnt_q <= (gh_q && !oh_q) ? TMR_W'(1) : (gh_q ? sh_cnt_q + TMR_W'(1) : '0);
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sl_q <= 1'b0;
         sh_q <= 1'b0;
      end
      else
      begin
         sl_q <= gl_q && (sl_cnt_q < sync_clamp_cycles);
         sh_q <= gh_q && (sh_cnt_q < sync_clamp_cycles);
      end
   end

   assign low_sync_out  = sl_q && gl_q && !kill;
   assign high_sync_out = sh_q && gh_q && !kill;

   ////////////////////////////////////////////////////////////////////////////
   // Status.

   assign overtemp_latched = ot_lat_q;
   assign shutdown_latched = sd_lat_q;
   assign running          = (phase_q == PLS_RUN);
   assign preheat_active   = (phase_q == PLS_PREHEAT);
   assign softstart_active = (phase_q == PLS_SOFTSTART);

endmodule

// [testbench/pls_sequencer_sva.sv]
module pls_sequencer_sva
   import pls_pkg::*;
#(
   parameter int unsigned FILT = FILT_CYCLES
)
(
   // Clock and reset.
   input wire logic             clk_sys,
   input wire logic             arst_n,
   // Comparator inputs.
   input wire logic             supply_ok_in,
   input wire logic             brownout_detect_input,
   input wire logic             overtemp_trip_in,
   input wire logic             latching_shutdown_input,
   input wire logic             fast_shutdown_input,
   input wire logic             boot_uvlo_in,
   // Outputs watched.
   input wire logic             low_gate_out,
   input wire logic             high_gate_out,
   input wire logic             low_sync_out,
   input wire logic             high_sync_out,
   input wire logic             overtemp_latched,
   input wire logic             shutdown_latched,
   input wire logic             running,
   input wire logic             softstart_active
);
   logic [15:0] ot_cnt_q;
   logic        outs_off;

   // Counts consecutive samples of a raised over-temperature pin.
   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
         ot_cnt_q <= 16'h0000;
      else if (!overtemp_trip_in)
         ot_cnt_q <= 16'h0000;
      else if (ot_cnt_q != 16'hFFFF)
         ot_cnt_q <= ot_cnt_q + 16'h0001;

   assign outs_off = !(low_gate_out || high_gate_out || low_sync_out || high_sync_out);

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   fast_blank_a: assert property (fast_shutdown_input[*3] |-> !low_gate_out && !high_gate_out)
      else $error("gates still driven during fast shutdown");
   ot_outs_off_a: assert property (overtemp_latched[*2] |-> outs_off)
      else $error("outputs active with overtemp latched");
   sd_outs_off_a: assert property (shutdown_latched[*2] |-> outs_off && !running)
      else $error("outputs active with shutdown latched");
   uvlo_high_a: assert property (boot_uvlo_in[*4] |-> !high_gate_out)
      else $error("high gate driven under floating supply lockout");
   sync_in_gate_a: assert property (!(low_sync_out && !low_gate_out) && !(high_sync_out && !high_gate_out))
      else $error("sync pulse outside its gate pulse");
   ot_run_only_a: assert property ($rose(overtemp_latched) |-> $past(running))
      else $error("overtemp latched during start-up");
   sd_late_arm_a: assert property ($rose(shutdown_latched) |-> $past(running || softstart_active))
      else $error("shutdown latched before preheat ended");
   ot_filter_a: assert property ($rose(overtemp_latched) |-> $past(ot_cnt_q, 3) >= FILT - 2)
      else $error("overtemp latched on a short pulse");
   ot_hold_a: assert property ((overtemp_latched && supply_ok_in && brownout_detect_input)[*6]
                               |=> overtemp_latched)
      else $error("overtemp latch dropped without clear event");

   ot_trip_c: cover property ($rose(overtemp_latched));
   sd_trip_c: cover property ($rose(shutdown_latched));
   fast_c: cover property (fast_shutdown_input[*3]);
endmodule

bind pls_sequencer pls_sequencer_sva #(.FILT(FILT)) u_pls_sequencer_sva (.clk_sys, .arst_n,
   .supply_ok_in, .brownout_detect_input, .overtemp_trip_in, .latching_shutdown_input,
   .fast_shutdown_input, .boot_uvlo_in, .low_gate_out, .high_gate_out, .low_sync_out,
   .high_sync_out, .overtemp_latched, .shutdown_latched, .running, .softstart_active);

// [testbench/pls_stage_model.sv]
module pls_stage_model
(
   // Clock and reset.
   input wire logic       clk_sys,
   input wire logic       arst_n,
   // Phase status and preheat length.
   input wire logic       preheat_active,
   input wire logic       softstart_active,
   input wire logic       running,
   input wire logic [7:0] ph_len,
   // Comparator and oscillator outputs.
   output logic           preheat_timer,
   output logic           softstart_done_in,
   output logic           osc_low_in,
   output logic           osc_high_in
);
   logic [7:0] ph_q;
   logic [3:0] osc_q;

   // Capacitor charges while the sequence is past the delay, discharged when off.
   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
         ph_q <= 8'h00;
      else if (!(preheat_active || softstart_active || running))
         ph_q <= 8'h00;
      else if (ph_q != 8'hFF)
         ph_q <= ph_q + 8'h01;

   // Free-running oscillator, ten cycles per period with dead time.
   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
         osc_q <= 4'h5;
      else
         osc_q <= (osc_q == 4'h9) ? 4'h0 : osc_q + 4'h1;

   assign preheat_timer     = ph_q >= ph_len;
   assign softstart_done_in = ph_q >= ph_len + 8'h08;
   assign osc_low_in        = osc_q < 4'h4;
   assign osc_high_in       = osc_q > 4'h4 && osc_q < 4'h9;
endmodule

// [testbench/testbench.sv]
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import pls_pkg::*;
   localparam int FILT_N = 8;
   logic clk_sys = 0, arst_n = 0, supply_ok_in = 0, brownout_detect_input = 0;
   logic overtemp_trip_in = 0, latching_shutdown_input = 0, fast_shutdown_input = 0;
   logic boot_uvlo_in = 0, preheat_timer, softstart_done_in, osc_low_in, osc_high_in;
   logic low_gate_out, high_gate_out, low_sync_out, high_sync_out, overtemp_latched;
   logic shutdown_latched, running, preheat_active, softstart_active;
   logic [TMR_W-1:0] sync_clamp_cycles = 24'h000002;
   logic [7:0] ph_len = 8'h06;
   logic [3:0] q[$];
   logic [3:0] n_w;
   logic [7:0] obs;
   int fails = 0, checks_done = 0, cyc = 0, seed = 51;
   event look;

   pls_sequencer #(.START_DELAY(20), .FILT(FILT_N), .BO_FILT(4)) u_pls_sequencer (.clk_sys,
      .arst_n, .supply_ok_in, .brownout_detect_input, .overtemp_trip_in,
      .latching_shutdown_input, .fast_shutdown_input, .preheat_timer, .softstart_done_in,
      .boot_uvlo_in, .osc_low_in, .osc_high_in, .sync_clamp_cycles, .low_gate_out,
      .high_gate_out, .low_sync_out, .high_sync_out, .overtemp_latched, .shutdown_latched,
      .running, .preheat_active, .softstart_active);
   pls_stage_model u_pls_stage_model (.clk_sys, .arst_n, .preheat_active, .softstart_active,
      .running, .ph_len, .preheat_timer, .softstart_done_in, .osc_low_in, .osc_high_in);

   assign obs = {high_sync_out, low_sync_out, preheat_active, running, high_gate_out,
                 low_gate_out, shutdown_latched, overtemp_latched};

   initial
      forever #5 clk_sys = ~clk_sys;

   task give_verdict;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         fails++;
         give_verdict();
      end
   end

   task check(input logic got, input logic exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Watcher takes the oldest expectation and compares it with the output it names.
   initial
      forever
      begin
         @(look);
         n_w = q.pop_front();
         check(obs[n_w[3:1]], n_w[0]);
      end

   task note(input logic [2:0] sel, input logic val);
      q.push_back({sel, val});
      ->look;
      #1;
   endtask

   task cycles(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task wait_for(input logic [2:0] sel, input logic val, input int lim);
      for (int i = 0; i < lim && obs[sel] !== val; i++)
         @(negedge clk_sys);
      note(sel, val);
   endtask

   task first_gate;
      for (int i = 0; i < 3000 && !(low_gate_out || high_gate_out); i++)
         @(negedge clk_sys);
      note(3'h2, 1'b1);
      note(3'h3, 1'b0);
   endtask

   initial
   begin
      cycles(5);
      arst_n = 1;
      supply_ok_in = 1;
      brownout_detect_input = 1;
      overtemp_trip_in = 1;
      first_gate();
      wait_for(3'h4, 1'b1, 500);
      note(3'h0, 1'b0);
      wait_for(3'h0, 1'b1, 50);
      note(3'h2, 1'b0);
      note(3'h3, 1'b0);
      $display("test overtemp latch done");
      overtemp_trip_in = 0;
      brownout_detect_input = 0;
      cycles(10);
      brownout_detect_input = 1;
      wait_for(3'h0, 1'b0, 20);
      first_gate();
      wait_for(3'h4, 1'b1, 500);
      repeat (4)
      begin
         overtemp_trip_in = 1;
         cycles(1 + $unsigned($random(seed)) % (FILT_N - 3));
         overtemp_trip_in = 0;
         cycles(3);
      end
      note(3'h0, 1'b0);
      $display("test brown-out clear done");
      latching_shutdown_input = 1;
      cycles(FILT_N + 6);
      latching_shutdown_input = 0;
      note(3'h1, 1'b1);
      cycles(40);
      note(3'h1, 1'b1);
      supply_ok_in = 0;
      ph_len = 8'h28;
      cycles(10);
      supply_ok_in = 1;
      wait_for(3'h1, 1'b0, 20);
      cycles(16);
      note(3'h5, 1'b0);
      wait_for(3'h5, 1'b1, 100);
      latching_shutdown_input = 1;
      cycles(FILT_N + 4);
      latching_shutdown_input = 0;
      note(3'h1, 1'b0);
      wait_for(3'h4, 1'b1, 500);
      $display("test latching shutdown done");
      ph_len = 8'h06;
      fast_shutdown_input = 1;
      cycles(3);
      note(3'h2, 1'b0);
      note(3'h3, 1'b0);
      cycles(10);
      note(3'h4, 1'b0);
      note(3'h6, 1'b0);
      note(3'h1, 1'b0);
      fast_shutdown_input = 0;
      wait_for(3'h5, 1'b1, 100);
      wait_for(3'h4, 1'b1, 500);
      note(3'h1, 1'b0);
      $display("test fast shutdown done");
      wait_for(3'h2, 1'b0, 20);
      wait_for(3'h6, 1'b1, 20);
      cycles(2);
      note(3'h6, 1'b0);
      note(3'h2, 1'b1);
      wait_for(3'h7, 1'b1, 20);
      cycles(2);
      note(3'h7, 1'b0);
      note(3'h3, 1'b1);
      $display("test sync clamp done");
      repeat (40)
      begin
         boot_uvlo_in = $random(seed);
         cycles(3);
      end
      boot_uvlo_in = 1;
      cycles(3);
      repeat (12)
      begin
         cycles(1);
         note(3'h3, 1'b0);
      end
      boot_uvlo_in = 0;
      wait_for(3'h3, 1'b1, 20);
      note(3'h4, 1'b1);
      $display("test floating supply lockout done");
      give_verdict();
   end
endmodule
